// >>> test/scd_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module scd_ctrl_model
   import scd_pkg::*;
(
   output scd_cmd_t cmd
);
   initial cmd = '1;
   // chip select high leaves the other lines as noise
   task automatic send(input logic cs_n, input logic [2:0] s,
      input logic [15:0] f);
      cmd = {cs_n, s, f};
   endtask
endmodule
`default_nettype wire

// >>> test/scd_decode_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module scd_decode_sva
   import scd_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire scd_cmd_t cmd,
   input wire logic rd_burst,
   input wire logic wr_burst,
   input wire scd_out_t dec_out,
   input wire logic [NUM_BANKS-1:0] bank_active,
   input wire logic [NUM_BANKS-1:0][ROW_W-1:0] open_row,
   input wire logic [ADDR_W-1:0] mode_reg,
   input wire scd_mask_t mask_out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   logic go;
   logic [2:0] s;
   logic [1:0] b;
   assign go = clk_en && !cmd.chip_sel_n;
   assign s = {cmd.row_strobe_n, cmd.col_strobe_n, cmd.write_en_n};
   assign b = {cmd.bank_sel_msb, cmd.bank_sel_lsb};
   AST_DESEL: assert property (clk_en && cmd.chip_sel_n |=>
      dec_out.op == SCD_OP_DESELECT && $stable(bank_active)) else $error("bad");
   AST_ACT: assert property (go && s == 3'b011 |=>
      dec_out.op == SCD_OP_ACTIVATE && bank_active[$past(b)] &&
      open_row[$past(b)] == $past(cmd.address_inputs)) else $error("bad");
   AST_PRE: assert property (
      go && s == 3'b010 && !cmd.address_inputs[AP_BIT]
      |=> !bank_active[$past(b)]) else $error("bad");
   AST_PALL: assert property (
      go && s == 3'b010 && cmd.address_inputs[AP_BIT]
      |=> bank_active == BANKS_IDLE) else $error("bad");
   AST_BANK: assert property (
      go && (s == 3'b011 || s[2:1] == 2'b10)
      |=> dec_out.bank == $past(b)) else $error("bad");
   AST_COL: assert property (go && s[2:1] == 2'b10 |=>
      dec_out.col_addr == $past(cmd.address_inputs[7:0]) &&
      dec_out.auto_precharge == $past(cmd.address_inputs[AP_BIT]))
      else $error("bad");
   AST_RW: assert property (go && s[2:1] == 2'b10 |=> dec_out.op ==
      ($past(cmd.write_en_n) ? SCD_OP_READ : SCD_OP_WRITE)) else $error("bad");
   AST_MODE: assert property (go && s == 3'b000 |=>
      mode_reg == $past(cmd.address_inputs)) else $error("bad");
   AST_RDM: assert property (clk_en && !rd_burst |=>
      mask_out.dq_drive_n == DRIVE_OFF_N) else $error("bad");
   AST_WRM: assert property (clk_en && wr_burst |=> mask_out.wr_byte_en ==
      ~$past({cmd.high_byte_mask, cmd.low_byte_mask})) else $error("bad");
   cover property (go && s == 3'b011);
   cover property (go && s == 3'b101);
   cover property (go && s == 3'b000);
   cover property (go && s == 3'b010 && cmd.address_inputs[AP_BIT]);
endmodule
bind scd_decode scd_decode_sva u_scd_decode_sva (.mclk, .reset, .clk_en,
   .cmd, .rd_burst, .wr_burst, .dec_out, .bank_active, .open_row, .mode_reg,
   .mask_out);
`default_nettype wire

// >>> test/scd_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
error_cnt++; $display("BAD %0t %h %h", $time, a, b); end end
module scd_decode_tb
   import scd_pkg::*;
;
   int error_cnt = 0;
   int samples_checked = 0;
   logic mclk = 0, reset = 1, clk_en = 1, rd_burst = 0, wr_burst = 0;
   scd_cmd_t cmd;
   scd_out_t dec_out;
   logic [NUM_BANKS-1:0] bank_active, eba = '0;
   logic [NUM_BANKS-1:0][ROW_W-1:0] open_row, erow = '0;
   logic [ADDR_W-1:0] mode_reg, emode = '0, a;
   scd_mask_t mask_out, emask = {DRIVE_OFF_N, BYTES_NONE};
   scd_op_t eop = SCD_OP_DESELECT;
   logic [LOC_W-1:0] eloc = '0;
   logic [COL_W-1:0] ecol = '0;
   logic [BANK_W-1:0] ebank = '0;
   logic [ROW_W-1:0] erowa = '0;
   logic eap = 0;
   logic [2:0] s;
   logic [1:0] b;
   logic [15:0] f;
   logic cs_n, e;
   always #10 mclk = ~mclk;
   scd_ctrl_model u_scd_ctrl_model (.cmd);
   scd_decode u_scd_decode (.mclk, .reset, .clk_en, .cmd, .rd_burst,
      .wr_burst, .dec_out, .bank_active, .open_row, .mode_reg, .mask_out);
   task automatic wrap_up;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp;
      `CHK(dec_out.op, eop)
      `CHK(bank_active, eba)
      `CHK(open_row, erow)
      `CHK(mode_reg, emode)
      `CHK(mask_out, emask)
      `CHK({dec_out.bank, dec_out.row_addr}, {ebank, erowa})
      `CHK({dec_out.auto_precharge, dec_out.col_addr}, {eap, ecol})
      `CHK(dec_out.loc_addr, eloc)
   endtask
   initial begin
      void'($urandom(78469));
      repeat (8) @(posedge mclk);
      #1 reset = 0;
      cmp();
      for (int i = 0; i < 400; i++) begin
         cs_n = ($urandom % 5) == 0;
         s = 3'(i);
         f = 16'($urandom);
         e = ($urandom % 8) != 0;
         u_scd_ctrl_model.send(cs_n, s, f);
         clk_en = e;
         rd_burst = 1'($urandom);
         wr_burst = 1'($urandom);
         // one mid-run reset, which must win over a low clock enable
         reset = (i == 200);
         b = f[15:14];
         a = f[13:2];
         if (reset) begin
            eop = SCD_OP_DESELECT;
            eba = '0;
            erow = '0;
            emode = '0;
            emask = {DRIVE_OFF_N, BYTES_NONE};
            ebank = '0;
            erowa = '0;
            ecol = '0;
            eloc = '0;
            eap = 0;
         end else if (e) begin
            emask.dq_drive_n = rd_burst ? f[1:0] : DRIVE_OFF_N;
            emask.wr_byte_en = wr_burst ? ~f[1:0] : BYTES_NONE;
            eop = cs_n ? SCD_OP_DESELECT : SCD_OP_OTHER;
            eap = 0;
            if (!cs_n) case (s)
               3'b011: begin
                  eop = SCD_OP_ACTIVATE;
                  eba[b] = 1;
                  erow[b] = a;
                  ebank = b;
                  erowa = a;
               end
               3'b010: begin
                  eop = a[AP_BIT] ? SCD_OP_PRECHARGE_ALL : SCD_OP_PRECHARGE;
                  if (a[AP_BIT]) begin
                     eba = '0;
                  end else begin
                     eba[b] = 0;
                     ebank = b;
                  end
               end
               3'b101, 3'b100: begin
                  eop = s[0] ? SCD_OP_READ : SCD_OP_WRITE;
                  ebank = b;
                  erowa = erow[b];
                  eap = a[AP_BIT];
                  ecol = a[COL_W-1:0];
                  eloc = {erow[b], ecol};
               end
               3'b000: begin
                  eop = SCD_OP_MODE_LOAD;
                  emode = a;
               end
               3'b111: eop = SCD_OP_NOP;
               default: eop = SCD_OP_OTHER;
            endcase
         end
         @(posedge mclk);
         #1 cmp();
      end
      wrap_up();
   end
   initial begin
      #20000;
      error_cnt++;
      wrap_up();
   end
endmodule
`default_nettype wire

// >>> verilog/scd_cmd_dec.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// combinational command decoder
// ***************************************************************
module scd_cmd_dec
   import scd_pkg::*;
(
   input wire scd_cmd_t cmd,
   output scd_dec_t dec
);

   logic [BANK_W-1:0] bank;
   logic [2:0] strobes;
   logic [NUM_BANKS-1:0] onehot;
   scd_op_t op;

   assign bank = {cmd.bank_sel_msb, cmd.bank_sel_lsb};
   assign strobes = {cmd.row_strobe_n, cmd.col_strobe_n, cmd.write_en_n};

   // one select line per bank
   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b = b + 1) begin : g_bank
         assign onehot[b] = (bank == BANK_W'(b));
      end
   endgenerate

   always_comb begin
      if (cmd.chip_sel_n) begin
         op = SCD_OP_DESELECT;
      end else begin
         case (strobes)
            3'h3: op = SCD_OP_ACTIVATE;
            3'h2: begin
               op = cmd.address_inputs[AP_BIT] ? SCD_OP_PRECHARGE_ALL
                                               : SCD_OP_PRECHARGE;
            end
            3'h5: op = SCD_OP_READ;
            3'h4: op = SCD_OP_WRITE;
            3'h0: op = SCD_OP_MODE_LOAD;
            3'h7: op = SCD_OP_NOP;
            default: op = SCD_OP_OTHER;
         endcase
      end
   end

   assign dec = '{
      op: op,
      bank: bank,
      bank_onehot: onehot,
      auto_pre: cmd.address_inputs[AP_BIT]
   };

endmodule
`default_nettype wire

// >>> verilog/scd_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - sample strobes each rising edge with clk_en high, decode
// - ignore commands while chip select high
// - row strobe alone opens selected bank
// - row strobe with write enable precharges bank
// - address bit ten precharges all banks
// - bank-select pair is binary bank number
// - activate takes twelve address bits as row
// - column bits zero-seven, bit ten auto precharge
// - row plus column address one million words
// - column strobe alone starts column access
// - write enable splits activate/precharge, read/write
// - mode load captures address as op code
// - byte masks gate drivers and writes
module scd_decode
   import scd_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire scd_cmd_t cmd,
   input wire logic rd_burst,
   input wire logic wr_burst,
   output scd_out_t dec_out,
   output logic [NUM_BANKS-1:0] bank_active,
   output logic [NUM_BANKS-1:0][ROW_W-1:0] open_row,
   output logic [ADDR_W-1:0] mode_reg,
   output scd_mask_t mask_out
);

   // ***************************************************************
   // reset image
   // ***************************************************************
   localparam scd_state_t STATE_RST = '{
      out: '{
         op: SCD_OP_DESELECT,
         bank: BANK_RST,
         row_addr: ROW_RST,
         col_addr: COL_RST,
         auto_precharge: 1'b0,
         loc_addr: {ROW_RST, COL_RST}
      },
      mask: '{dq_drive_n: DRIVE_OFF_N, wr_byte_en: BYTES_NONE},
      bank_active: BANKS_IDLE,
      open_row: '0,
      mode_reg: MODE_RST
   };

   // ***************************************************************
   // state and helper signals
   // ***************************************************************
   scd_state_t state_r;
   scd_state_t state_nxt;
   scd_dec_t dec;
   logic [MASK_W-1:0] byte_mask;
   logic [COL_W-1:0] col_in;
   logic [ROW_W-1:0] sel_row;
   logic is_activate;
   logic is_precharge;
   logic is_precharge_all;
   logic is_column;
   logic is_mode_load;
   logic [NUM_BANKS-1:0] bank_open_set;
   logic [NUM_BANKS-1:0] bank_open_clr;
   logic [NUM_BANKS-1:0] bank_active_nxt;
   logic [NUM_BANKS-1:0][ROW_W-1:0] open_row_nxt;
   logic [MASK_W-1:0] dq_drive_n_nxt;
   logic [MASK_W-1:0] wr_byte_en_nxt;
   scd_out_t out_nxt;
   logic [ADDR_W-1:0] mode_nxt;

   // ***************************************************************
   // command decode
   // ***************************************************************
   scd_cmd_dec u_dec (
      .cmd(cmd),
      .dec(dec)
   );

   // ***************************************************************
   // command classes
   // ***************************************************************
   // deselect, no-op and codes this block does not serve fall out here and leave
   // bank, row, column and mode fields alone; op still updates, auto_precharge clears
   always_comb begin
      is_activate = 1'b0;
      is_precharge = 1'b0;
      is_precharge_all = 1'b0;
      is_column = 1'b0;
      is_mode_load = 1'b0;
      case (dec.op)
         SCD_OP_ACTIVATE: begin
            is_activate = 1'b1;
         end
         SCD_OP_PRECHARGE: begin
            is_precharge = 1'b1;
         end
         SCD_OP_PRECHARGE_ALL: begin
            is_precharge_all = 1'b1;
         end
         SCD_OP_READ, SCD_OP_WRITE: begin
            is_column = 1'b1;
         end
         SCD_OP_MODE_LOAD: begin
            is_mode_load = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // ***************************************************************
   // bank state
   // ***************************************************************
   assign bank_open_set = is_activate ? dec.bank_onehot : BANKS_IDLE;
   always_comb begin
      bank_open_clr = BANKS_IDLE;
      if (is_precharge_all) begin
         bank_open_clr = BANKS_ALL;
      end else if (is_precharge) begin
         bank_open_clr = dec.bank_onehot;
      end
   end

   // one command never both opens and closes the same bank
   genvar g;
   generate
      for (g = 0; g < NUM_BANKS; g = g + 1) begin : g_bank
         assign bank_active_nxt[g] = bank_open_set[g] |
            (state_r.bank_active[g] & ~bank_open_clr[g]);
         assign open_row_nxt[g] = bank_open_set[g] ?
            cmd.address_inputs : state_r.open_row[g];
      end
   endgenerate

   // ***************************************************************
   // column access
   // ***************************************************************
   // a column command to an idle bank still decodes, using the row that
   // bank opened last
   assign col_in = cmd.address_inputs[COL_W-1:0];
   assign sel_row = state_r.open_row[dec.bank];

   // ***************************************************************
   // data masks
   // ***************************************************************
   assign byte_mask = {cmd.high_byte_mask, cmd.low_byte_mask};

   // masks act every edge with clk_en high, commands or not
   genvar m;
   generate
      for (m = 0; m < MASK_W; m = m + 1) begin : g_byte
         assign dq_drive_n_nxt[m] = rd_burst ? byte_mask[m]
                                             : DRIVE_OFF_N[m];
         assign wr_byte_en_nxt[m] = wr_burst ? ~byte_mask[m]
                                             : BYTES_NONE[m];
      end
   endgenerate

   // ***************************************************************
   // decode results
   // ***************************************************************
   always_comb begin
      out_nxt = state_r.out;
      out_nxt.op = dec.op;
      out_nxt.auto_precharge = 1'b0;
      if (is_activate) begin
         out_nxt.bank = dec.bank;
         out_nxt.row_addr = cmd.address_inputs;
      end
      if (is_precharge) begin
         out_nxt.bank = dec.bank;
      end
      if (is_column) begin
         out_nxt.bank = dec.bank;
         out_nxt.row_addr = sel_row;
         out_nxt.col_addr = col_in;
         out_nxt.auto_precharge = dec.auto_pre;
         out_nxt.loc_addr = {sel_row, col_in};
      end
   end

   // ***************************************************************
   // mode register
   // ***************************************************************
   assign mode_nxt = is_mode_load ? cmd.address_inputs
                                  : state_r.mode_reg;

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      state_nxt = state_r;
      state_nxt.out = out_nxt;
      state_nxt.mask.dq_drive_n = dq_drive_n_nxt;
      state_nxt.mask.wr_byte_en = wr_byte_en_nxt;
      state_nxt.bank_active = bank_active_nxt;
      state_nxt.open_row = open_row_nxt;
      state_nxt.mode_reg = mode_nxt;
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_r <= STATE_RST;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   assign dec_out = state_r.out;
   assign bank_active = state_r.bank_active;
   assign open_row = state_r.open_row;
   assign mode_reg = state_r.mode_reg;
   assign mask_out = state_r.mask;

endmodule
`default_nettype wire

// >>> verilog/scd_pkg.sv
// ***************************************************************
// shared constants and types
// ***************************************************************
package scd_pkg;

   localparam int NUM_BANKS = 4;
   localparam int BANK_W = 2;
   localparam int ADDR_W = 12;
   localparam int ROW_W = 12;
   localparam int COL_W = 8;
   localparam int LOC_W = ROW_W + COL_W;
   localparam int AP_BIT = 10;
   localparam int MASK_W = 2;
   localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
   localparam logic [ROW_W-1:0] ROW_RST = 12'h000;
   localparam logic [COL_W-1:0] COL_RST = 8'h00;
   localparam logic [BANK_W-1:0] BANK_RST = 2'h0;
   localparam logic [NUM_BANKS-1:0] BANKS_IDLE = 4'h0;
   localparam logic [NUM_BANKS-1:0] BANKS_ALL = 4'hF;
   localparam logic [MASK_W-1:0] DRIVE_OFF_N = 2'h3;
   localparam logic [MASK_W-1:0] BYTES_NONE = 2'h0;

   typedef enum logic [3:0] {
      SCD_OP_DESELECT,
      SCD_OP_NOP,
      SCD_OP_ACTIVATE,
      SCD_OP_PRECHARGE,
      SCD_OP_PRECHARGE_ALL,
      SCD_OP_READ,
      SCD_OP_WRITE,
      SCD_OP_MODE_LOAD,
      SCD_OP_OTHER
   } scd_op_t;

   // command pins as sampled from the memory controller
   typedef struct packed {
      logic chip_sel_n;
      logic row_strobe_n;
      logic col_strobe_n;
      logic write_en_n;
      logic bank_sel_msb;
      logic bank_sel_lsb;
      logic [ADDR_W-1:0] address_inputs;
      logic high_byte_mask;
      logic low_byte_mask;
   } scd_cmd_t;

   // decoded view of one command
   typedef struct packed {
      scd_op_t op;
      logic [BANK_W-1:0] bank;
      logic [NUM_BANKS-1:0] bank_onehot;
      logic auto_pre;
   } scd_dec_t;

   // decode results presented to the core
   typedef struct packed {
      scd_op_t op;
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0] row_addr;
      logic [COL_W-1:0] col_addr;
      logic auto_precharge;
      logic [LOC_W-1:0] loc_addr;
   } scd_out_t;

   // data mask controls
   typedef struct packed {
      logic [MASK_W-1:0] dq_drive_n;
      logic [MASK_W-1:0] wr_byte_en;
   } scd_mask_t;

   // whole state of the top module
   typedef struct packed {
      scd_out_t out;
      scd_mask_t mask;
      logic [NUM_BANKS-1:0] bank_active;
      logic [NUM_BANKS-1:0][ROW_W-1:0] open_row;
      logic [ADDR_W-1:0] mode_reg;
   } scd_state_t;

endpackage
